/* File: design/odrp_port.v */
/*
 * On-demand request port of a four-channel DMA controller, with an APB
 * register slave. Decodes format words and pulse requests from an
 * external device, loads channel 0 and queues requests for channels 1-3.
 * Assumes pclk is the bus clock, the DMA core runs on pclk, and the
 * external pins are asynchronous to it (two-flop synchronised here).
 */
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
`include "odrp_defines.vh"

// Function
// - Writing on_demand_mode to one enables request pins and format handling.
// - An accepted bus release request is answered with bus_available_flag.
// - The data bus is released two cycles after bus_available_flag.
// - Data pins stay undriven from the flag cycle to one cycle after release.
// - Channel 0 format word loads channel 0 registers, then transfer starts.
// - Channels 1-3 are preset by software; the word selects the channel, or with unit size 110 clears its queue.
// - Handshake request: channel 00, mode 00, unit size not 101, 110 or 111.
// - Last requested channel is recorded; a lone pulse re-requests it.
// - Release request with pulse together requests channel 2 directly.
// - Acknowledge reply is active low, timed like the memory acknowledge.
// - Channel code 00,01,10,11 selects channel 0,1,2,3.
// - Format word is 64 bits on data 63:0; bits 47:32 ignored.
// - Channel 0 requests allow single address mode only.
// - Channel 0 word sets step modes, source select, polarities, irq, size.
// - Sense and transfer style follow mode; count and address are loaded.
// - Base variant: channel 0 registers read-only to CPU in on-demand mode.
// - Later variant: CPU may write them; a later word overwrites them.
// - Bits 63:61 are the unit size code with clear and end codes.
// - Bit 60 is the direction: 0 memory read, 1 memory write.
// - Bits 59:58 carry the channel number, same coding as the pins.
// - Bits 57:56 are request mode: handshake, edge, level, cycle steal.
// - Bits 55:48 are the count; zero means the 16M maximum.
// - Bits 31:0 are source address for reads, destination for writes.
// - Channels 1-3 queue four requests each; extra requests are dropped.
module odrp_port #(
	parameter LATER_VARIANT = 1'b1,
	parameter QDEPTH = `ODRP_QUEUE_DEPTH
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire bus_release_request_n,
	input wire xfer_demand_pulse_n,
	input wire [63:0] data_in,
	output reg bus_available_flag_n,
	output reg data_drive_inhibit,
	output reg [1:0] channel_select,
	input wire mem_ack_line_n,
	output wire device_ack_reply_n,
	output reg [3:0] chan_request,
	input wire [3:0] chan_done,
	output reg chan0_end
);

	reg [1:0] rel_s1_q, rel_s2_q;
	reg [63:0] dat_s1_q, dat_s2_q;
	reg [31:0] oper_q;
	reg [15:0] ctl0_q;
	reg [31:0] src0_q, dst0_q;
	reg [23:0] cnt0_q;
	reg [1:0] last_ch_q;
	reg last_valid_q;
	reg [`ODRP_RELEASE_DLY+`ODRP_SYNC_LAG:0] bus_available_flag_hist_q;
	reg [2:0] inhibit_hist_q;
	reg [2:0] qcnt_q [1:3];
	reg [31:0] rd_d;
	wire odm, rel_req, tr_req, bus_available_flag_now;
	wire fw_take, direct2, lone;
	wire [2:0] usz;
	wire [1:0] fch, fmode;
	wire ch0_load, ch0_hshake, ch0_stop, cpu_wr, ch0_cpu_ok;
	reg [3:0] push;
	reg [3:0] qclr;
	integer i;

	assign odm = oper_q[`ODRP_OPER_ODM];
	// Synchronised pins, active high after the second flop
	assign rel_req = odm & rel_s2_q[0];
	assign tr_req = odm & rel_s2_q[1];

	// Fields of the sampled word; bits 47:32 never read
	assign usz = dat_s2_q[`ODRP_FW_USZ_HI:`ODRP_FW_USZ_LO];
	assign fch = dat_s2_q[`ODRP_FW_CH_HI:`ODRP_FW_CH_LO];
	assign fmode = dat_s2_q[`ODRP_FW_MODE_HI:`ODRP_FW_MODE_LO];

	// Pin pulse two cycles after the flag, seen here after the sync lag
	assign fw_take = tr_req & bus_available_flag_hist_q[`ODRP_RELEASE_DLY+`ODRP_SYNC_LAG];
	assign direct2 = tr_req & rel_req & ~fw_take;
	assign lone = tr_req & ~rel_req & ~fw_take;
	// Flag answers a release request that has no pulse beside it
	assign bus_available_flag_now = rel_req & ~tr_req & ~(|bus_available_flag_hist_q) & ~(|inhibit_hist_q);

	assign ch0_load = fw_take & (fch == `ODRP_CH0) & (fmode != `ODRP_MODE_HSHAKE)
		& (usz != `ODRP_USZ_END) & (usz != `ODRP_USZ_QCLR) & (usz != `ODRP_USZ_BAD);
	assign ch0_hshake = fw_take & (fch == `ODRP_CH0) & (fmode == `ODRP_MODE_HSHAKE)
		& (usz != `ODRP_USZ_BAD) & (usz != `ODRP_USZ_QCLR) & (usz != `ODRP_USZ_END);
	assign ch0_stop = fw_take & (fch == `ODRP_CH0) & (usz == `ODRP_USZ_END);

	assign cpu_wr = psel & penable & pwrite;
	assign ch0_cpu_ok = ~odm | LATER_VARIANT;
	assign pready = 1'b1;
	assign pslverr = psel & penable & (paddr > `ODRP_OFF_STAT | paddr[1:0] != 2'b00
		| (pwrite & ~ch0_cpu_ok & paddr >= `ODRP_OFF_CTL0 & paddr <= `ODRP_OFF_CNT0)
		| (pwrite & paddr == `ODRP_OFF_STAT));
	// Same timing as the memory acknowledge, only gated by the mode
	assign device_ack_reply_n = ~(odm & ~mem_ack_line_n);

	// Request routing per channel
	always @* begin
		push = 4'b0000;
		qclr = 4'b0000;
		if (fw_take) begin
			if (fch != `ODRP_CH0) begin
				if (usz == `ODRP_USZ_QCLR)
					qclr[fch] = 1'b1;
				else
					push[fch] = 1'b1;
			end else if (ch0_load | ch0_hshake) begin
				push[0] = 1'b1;
			end
		end else if (direct2) begin
			push[2] = 1'b1;
		end else if (lone & last_valid_q) begin
			push[last_ch_q] = 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rel_s1_q <= 2'b00;
			rel_s2_q <= 2'b00;
			dat_s1_q <= 64'h0000_0000_0000_0000;
			dat_s2_q <= 64'h0000_0000_0000_0000;
		end else begin
			// Sampled on every rising edge of the bus clock
			rel_s1_q <= {~xfer_demand_pulse_n, ~bus_release_request_n};
			rel_s2_q <= rel_s1_q;
			dat_s1_q <= data_in;
			dat_s2_q <= dat_s1_q;
		end
	end

	// Bus release sequence
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_available_flag_hist_q <= {(`ODRP_RELEASE_DLY+`ODRP_SYNC_LAG+1){1'b0}};
			inhibit_hist_q <= 3'b000;
			bus_available_flag_n <= 1'b1;
			data_drive_inhibit <= 1'b0;
		end else begin
			bus_available_flag_n <= ~bus_available_flag_now;
			bus_available_flag_hist_q <= {bus_available_flag_hist_q[`ODRP_RELEASE_DLY+`ODRP_SYNC_LAG-1:0], bus_available_flag_now};
			// Release falls at flag+2; inhibit flag .. flag+3
			inhibit_hist_q <= {inhibit_hist_q[1:0], bus_available_flag_now};
			data_drive_inhibit <= (|inhibit_hist_q) | bus_available_flag_now;
		end
	end

	// Last channel record and channel notification
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_valid_q <= 1'b0;
			last_ch_q <= `ODRP_CH0;
			channel_select <= `ODRP_CH0;
		end else if (!odm) begin
			last_valid_q <= 1'b0;
		end else if (fw_take & (usz != `ODRP_USZ_QCLR) & (usz != `ODRP_USZ_END)) begin
			last_valid_q <= 1'b1;
			last_ch_q <= fch;
			channel_select <= fch;
		end else if (direct2) begin
			last_valid_q <= 1'b1;
			last_ch_q <= `ODRP_CH2;
			channel_select <= `ODRP_CH2;
		end
	end

	// Channel 0 registers; a format word wins over a CPU write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oper_q <= `ODRP_OPER_RST;
			ctl0_q <= `ODRP_CTL_RST;
			src0_q <= 32'h0000_0000;
			dst0_q <= 32'h0000_0000;
			cnt0_q <= 24'h00_0000;
		end else begin
			if (cpu_wr & paddr == `ODRP_OFF_OPER)
				oper_q <= {31'h0000_0000, pwdata[`ODRP_OPER_ODM]};
			if (ch0_load) begin
				// Single address mode only: one address register is loaded
				ctl0_q[`ODRP_CTL_DSTEP_HI:`ODRP_CTL_DSTEP_LO] <= `ODRP_STEP_INC;
				ctl0_q[`ODRP_CTL_SSTEP_HI:`ODRP_CTL_SSTEP_LO] <= `ODRP_STEP_INC;
				ctl0_q[`ODRP_CTL_RSRC_HI:`ODRP_CTL_RSRC_LO] <=
					dat_s2_q[`ODRP_FW_DIR] ? `ODRP_RSRC_WRITE : `ODRP_RSRC_READ;
				ctl0_q[`ODRP_CTL_REQ_POL] <= 1'b0;
				ctl0_q[`ODRP_CTL_ACK_POL] <= 1'b0;
				ctl0_q[`ODRP_CTL_IRQ_EN] <= 1'b0;
				ctl0_q[`ODRP_CTL_USZ_HI:`ODRP_CTL_USZ_LO] <= usz;
				ctl0_q[`ODRP_CTL_SENSE] <= (fmode == `ODRP_MODE_EDGE);
				ctl0_q[`ODRP_CTL_STYLE] <= (fmode != `ODRP_MODE_STEAL);
				// Zero count kept as zero: the core treats it as 16M
				cnt0_q <= {16'h0000, dat_s2_q[`ODRP_FW_CNT_HI:`ODRP_FW_CNT_LO]};
				if (dat_s2_q[`ODRP_FW_DIR])
					dst0_q <= dat_s2_q[`ODRP_FW_ADR_HI:0];
				else
					src0_q <= dat_s2_q[`ODRP_FW_ADR_HI:0];
			end else if (cpu_wr & ch0_cpu_ok) begin
				case (paddr)
				`ODRP_OFF_CTL0: ctl0_q <= pwdata[15:0];
				`ODRP_OFF_SRC0: src0_q <= pwdata;
				`ODRP_OFF_DST0: dst0_q <= pwdata;
				`ODRP_OFF_CNT0: cnt0_q <= pwdata[23:0];
				default: ;
				endcase
			end
		end
	end

	// Channel 0 request: set wins over the done clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_request[0] <= 1'b0;
			chan0_end <= 1'b0;
		end else begin
			chan0_end <= ch0_stop;
			if (push[0])
				chan_request[0] <= 1'b1;
			else if (chan_done[0] | ch0_stop | ~odm)
				chan_request[0] <= 1'b0;
		end
	end

	// Request queues of channels 1 to 3
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (i = 1; i < 4; i = i + 1) begin
				qcnt_q[i] <= 3'b000;
				chan_request[i] <= 1'b0;
			end
		end else begin
			for (i = 1; i < 4; i = i + 1) begin
				if (qclr[i] | ~odm)
					qcnt_q[i] <= 3'b000;
				else if (push[i] & (qcnt_q[i] != QDEPTH[2:0]) & ~(chan_done[i] & qcnt_q[i] != 3'b000))
					qcnt_q[i] <= qcnt_q[i] + 3'b001;
				else if (chan_done[i] & (qcnt_q[i] != 3'b000) & ~push[i])
					qcnt_q[i] <= qcnt_q[i] - 3'b001;
				chan_request[i] <= ~qclr[i] & odm & ((qcnt_q[i] != 3'b000) | push[i])
					& ~(chan_done[i] & qcnt_q[i] == 3'b001 & ~push[i]);
			end
		end
	end

	// Read data captured in the setup phase
	always @* begin
		case (paddr)
		`ODRP_OFF_OPER: rd_d = oper_q;
		`ODRP_OFF_CTL0: rd_d = {16'h0000, ctl0_q};
		`ODRP_OFF_SRC0: rd_d = src0_q;
		`ODRP_OFF_DST0: rd_d = dst0_q;
		`ODRP_OFF_CNT0: rd_d = {8'h00, cnt0_q};
		`ODRP_OFF_STAT: rd_d = {12'h000, chan_request, 1'b0, qcnt_q[3], 1'b0, qcnt_q[2],
			1'b0, qcnt_q[1], last_valid_q, 1'b0, last_ch_q};
		default: rd_d = 32'h0000_0000;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable)
			prdata <= rd_d;
	end

endmodule

/* File: shared/odrp_defines.vh */
/*
 * Constants of the on-demand DMA request port: register offsets,
 * field positions, reset values, format word layout and pin timing.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef ODRP_DEFINES_VH
`define ODRP_DEFINES_VH

// Register byte offsets
`define ODRP_OFF_OPER 12'h000
`define ODRP_OFF_CTL0 12'h004
`define ODRP_OFF_SRC0 12'h008
`define ODRP_OFF_DST0 12'h00C
`define ODRP_OFF_CNT0 12'h010
`define ODRP_OFF_STAT 12'h014

// dma_operation_reg fields
`define ODRP_OPER_ODM 0
`define ODRP_OPER_RST 32'h0000_0000

// chan0_control_reg fields
`define ODRP_CTL_REQ_POL 0
`define ODRP_CTL_SENSE 1
`define ODRP_CTL_IRQ_EN 2
`define ODRP_CTL_ACK_POL 3
`define ODRP_CTL_USZ_LO 4
`define ODRP_CTL_USZ_HI 6
`define ODRP_CTL_STYLE 7
`define ODRP_CTL_RSRC_LO 8
`define ODRP_CTL_RSRC_HI 11
`define ODRP_CTL_SSTEP_LO 12
`define ODRP_CTL_SSTEP_HI 13
`define ODRP_CTL_DSTEP_LO 14
`define ODRP_CTL_DSTEP_HI 15
`define ODRP_CTL_RST 16'h0000

// Values loaded from a channel 0 format word
`define ODRP_STEP_INC 2'b01
`define ODRP_RSRC_READ 4'b0010
`define ODRP_RSRC_WRITE 4'b0011

// Format word layout
`define ODRP_FW_USZ_HI 63
`define ODRP_FW_USZ_LO 61
`define ODRP_FW_DIR 60
`define ODRP_FW_CH_HI 59
`define ODRP_FW_CH_LO 58
`define ODRP_FW_MODE_HI 57
`define ODRP_FW_MODE_LO 56
`define ODRP_FW_CNT_HI 55
`define ODRP_FW_CNT_LO 48
`define ODRP_FW_ADR_HI 31

// unit_size_code values
`define ODRP_USZ_BAD 3'b101
`define ODRP_USZ_QCLR 3'b110
`define ODRP_USZ_END 3'b111

// request_mode_code values
`define ODRP_MODE_HSHAKE 2'b00
`define ODRP_MODE_EDGE 2'b01
`define ODRP_MODE_STEAL 2'b11

// Channel codes
`define ODRP_CH0 2'b00
`define ODRP_CH2 2'b10

// Pin timing, in bus clock cycles
`define ODRP_RELEASE_DLY 2
// Flop stages between a pin and the decode logic
`define ODRP_SYNC_LAG 2
`define ODRP_QUEUE_DEPTH 4

`endif

/* File: tb/odrp_port_asserts.sv */
/* Checker for the on-demand request port pins and APB answer.
   Assumes binding to odrp_port, all pins synchronous to pclk. */
`timescale 1ns/100ps
module odrp_chk (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [11:0] paddr,
	input logic pready,
	input logic pslverr,
	input logic bus_release_request_n,
	input logic bus_available_flag_n,
	input logic data_drive_inhibit,
	input logic mem_ack_line_n,
	input logic device_ack_reply_n,
	input logic chan0_end
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_flag_one_pulse: assert property ($fell(bus_available_flag_n) |=> bus_available_flag_n[*4])
		else $error("flag pulse too long");
	a_flag_has_cause: assert property ($fell(bus_available_flag_n) |->
		!$past(bus_release_request_n, 3) || !$past(bus_release_request_n, 4))
		else $error("flag without release request");
	a_inhibit_span: assert property ($fell(bus_available_flag_n) |=> data_drive_inhibit[*3])
		else $error("data pins not held off");
	a_inhibit_ends: assert property ($rose(data_drive_inhibit) |-> ##[1:6] !data_drive_inhibit)
		else $error("inhibit stuck");
	a_ack_follows: assert property (!device_ack_reply_n |-> !mem_ack_line_n)
		else $error("reply without memory ack");
	a_end_pulse: assert property (chan0_end |=> !chan0_end)
		else $error("end pulse too long");
	a_apb_ready: assert property (psel && penable |-> pready)
		else $error("wait state seen");
	a_stat_ro: assert property (psel && penable && pwrite && paddr == 12'h014 |-> pslverr)
		else $error("status write accepted");
	a_bad_addr: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
		else $error("unmapped access accepted");
endmodule
bind odrp_port odrp_chk i_odrp_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.bus_release_request_n(bus_release_request_n), .bus_available_flag_n(bus_available_flag_n),
	.data_drive_inhibit(data_drive_inhibit), .mem_ack_line_n(mem_ack_line_n),
	.device_ack_reply_n(device_ack_reply_n), .chan0_end(chan0_end));

/* File: tb/odrp_ext_dev.sv */
/* External requesting device: format word, lone pulse or direct request.
   Assumes go is a one-cycle command from the bench, kind 0/1/2. */
`timescale 1ns/100ps
module odrp_ext_dev (
	input logic pclk,
	input logic presetn,
	input logic go,
	input logic [1:0] kind,
	input logic [63:0] word,
	input logic bus_available_flag_n,
	output logic bus_release_request_n,
	output logic xfer_demand_pulse_n,
	output logic [63:0] data_in,
	output logic busy
);
	logic [2:0] st;
	assign busy = st != 3'd0;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= 3'd0;
			bus_release_request_n <= 1'b1;
			xfer_demand_pulse_n <= 1'b1;
			data_in <= 64'h0;
		end else begin
			xfer_demand_pulse_n <= 1'b1;
			// Released bus toggles so stale data never looks valid
			data_in <= ~data_in;
			case (st)
				3'd0: if (go) begin
					bus_release_request_n <= kind == 2'd1;
					xfer_demand_pulse_n <= kind == 2'd0;
					st <= kind == 2'd0 ? 3'd1 : kind == 2'd2 ? 3'd2 : 3'd0;
				end
				3'd1: if (!bus_available_flag_n) begin
					bus_release_request_n <= 1'b1;
					st <= 3'd3;
				end
				3'd2: begin
					bus_release_request_n <= 1'b1;
					st <= 3'd0;
				end
				default: begin
					data_in <= word;
					xfer_demand_pulse_n <= 1'b0;
					st <= 3'd0;
				end
			endcase
		end
	end
endmodule

/* File: tb/testbench.sv */
/* Self-checking bench for odrp_port with an external device model.
   Assumes the design answers APB with no wait states. */
`timescale 1ns/100ps
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, err;
	logic mem_ack_line_n = 1, pready, pslverr, rel_n, pul_n, flag_n, busy;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0] chan_done = 0, chan_request;
	logic [63:0] word = 0, dbus, w;
	logic [1:0] kind = 0, channel_select;
	logic device_ack_reply_n;
	int miscompares = 0, samples_checked = 0, cyc = 0;
	always #2 pclk = ~pclk;
	always @(posedge pclk) mem_ack_line_n <= 1'($urandom);
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			final_report;
		end
	end
	odrp_port i_odrp_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus_release_request_n(rel_n), .xfer_demand_pulse_n(pul_n),
		.data_in(dbus), .bus_available_flag_n(flag_n), .data_drive_inhibit(),
		.channel_select(channel_select), .mem_ack_line_n(mem_ack_line_n),
		.device_ack_reply_n(device_ack_reply_n), .chan_request(chan_request),
		.chan_done(chan_done), .chan0_end());
	odrp_ext_dev i_odrp_ext_dev (.pclk(pclk), .presetn(presetn), .go(go), .kind(kind),
		.word(word), .bus_available_flag_n(flag_n), .bus_release_request_n(rel_n),
		.xfer_demand_pulse_n(pul_n), .data_in(dbus), .busy(busy));
	task final_report;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task send(input logic [1:0] k, input logic [63:0] fw);
		@(posedge pclk);
		kind <= k;
		word <= fw;
		go <= 1;
		@(posedge pclk);
		go <= 0;
		repeat (2) @(posedge pclk);
		while (busy) @(posedge pclk);
		// Two sync stages plus decode and register
		repeat (8) @(posedge pclk);
	endtask
	function logic [15:0] ctl(input logic [63:0] f);
		ctl = {4'b0101, 3'b001, f[60], f[57:56] != 2'b11, f[63:61], 2'b00, f[57:56] == 2'b01, 1'b0};
	endfunction
	initial begin
		void'($urandom(32'hc794));
		repeat (20) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h000, 0);
		chk("oper", 0, rd);
		apb(0, 12'h004, 0);
		chk("ctl0 reset", 0, rd);
		apb(0, 12'h020, 0);
		chk("unmapped", 1, err);
		apb(1, 12'h014, 0);
		chk("stat ro", 1, err);
		apb(1, 12'h000, 32'h0000_0001);
		send(1, 0);
		chk("early lone", 0, chan_request);
		for (int i = 0; i < 4; i++) begin
			w = {3'($urandom_range(4)), 1'($urandom), 2'b00, 2'($urandom_range(3, 1)),
				8'($urandom), 16'($urandom), 32'($urandom)};
			if (i == 0)
				w[55:48] = 8'h00;
			apb(1, 12'h004, $urandom);
			send(0, w);
			chk("chsel0", 0, channel_select);
			apb(0, 12'h004, 0);
			chk("ctl0", ctl(w), rd);
			apb(0, w[60] ? 12'h00c : 12'h008, 0);
			chk("addr0", w[31:0], rd);
			apb(0, 12'h010, 0);
			chk("count0", w[55:48], rd);
		end
		send(0, {3'b111, 1'b0, 2'b00, 2'b01, 56'h0});
		chk("ch0 ended", 0, chan_request[0]);
		// Handshake word: requests channel 0 but leaves its registers alone
		send(0, 64'h0000_0000_0000_0000);
		chk("hshake req", 1, chan_request[0]);
		apb(0, 12'h004, 0);
		chk("hshake ctl0", ctl(w), rd);
		for (int ch = 1; ch < 4; ch++) begin
			send(0, {4'h0, 2'(ch), 26'h0, 32'($urandom)});
			chk("chsel", ch, channel_select);
			chk("req", 1, chan_request[ch]);
		end
		repeat (4) send(0, {4'h0, 2'b11, 58'h0});
		apb(0, 12'h014, 0);
		chk("q3 full", 4, rd[14:12]);
		repeat (4) begin
			@(posedge pclk) chan_done <= 4'b1000;
			@(posedge pclk) chan_done <= 4'b0000;
		end
		repeat (2) @(posedge pclk);
		chk("q3 drained", 0, chan_request[3]);
		send(1, 0);
		chk("lone", 1, chan_request[3]);
		send(2, 0);
		chk("direct", 2, channel_select);
		apb(0, 12'h014, 0);
		chk("q2", 2, rd[10:8]);
		// Queue clear word on channel 2; last channel must not move
		send(0, {3'b110, 1'b0, 2'b10, 58'h0});
		chk("q2 cleared", 0, chan_request[2]);
		apb(0, 12'h014, 0);
		chk("q2 empty", 0, rd[10:8]);
		chk("last ch", 4'b1010, rd[3:0]);
		chk("ack on", mem_ack_line_n, device_ack_reply_n);
		apb(1, 12'h000, 0);
		repeat (2) @(posedge pclk);
		chk("ack off", 1, device_ack_reply_n);
		chk("flush", 0, chan_request);
		final_report;
	end
endmodule
